// file: include/fsd_consts.svh
// Constants for the feature-set command decoder: offsets, codes, bit positions, defaults.
// Operation
// - Opcode EE is identify-by-DMA; without DMA it acts as plain identify.
// - Host writes opcode EF to command_code; device treats it as feature change.
// - On accepting it, set busy_flag and capture feature_select as the code.
// - After applying the code, clear busy_flag, then raise the interrupt.
// - Unsupported or invalid code ends with ABORTED COMMAND in fault_detail and status.
// - Code 03 sets transfer mode; sector_count holds the mode argument.
// - PIO 4, single-word DMA 2 and multiword DMA stay supported always; the block aborts every single-word DMA argument.
// - Code 02 enables write cache; code 82 disables it.
// - Code AA enables read cache; code 55 disables it.
// - Code 05 turns power management on; code 85 turns it off.
// - Code 66 keeps settings through soft reset; CC restores reverting.
// - Code BB selects a four-byte ECC field for long commands.
// - Transfer argument: upper five bits type, lower three bits mode number.
// - Power-on and hardware reset take the above-AA defaults, write cache aside; the block resets write cache to its default as well.
// - Unsupported transfer-mode argument posts ABORTED COMMAND.
`ifndef FSD_CONSTS_SVH
`define FSD_CONSTS_SVH

// =====================================================================
// Task-file addresses.
`define FSD_ADDR_FEATURE 10'h1f1
`define FSD_ADDR_SCOUNT 10'h1f2
`define FSD_ADDR_SNUMBER 10'h1f3
`define FSD_ADDR_CYL_LO 10'h1f4
`define FSD_ADDR_CYL_HI 10'h1f5
`define FSD_ADDR_DRVHEAD 10'h1f6
`define FSD_ADDR_COMMAND 10'h1f7

// =====================================================================
// Opcodes and feature codes.
`define FSD_OP_IDENT_DMA 8'hee
`define FSD_OP_SET_FEAT 8'hef
`define FSD_FC_WC_ON 8'h02
`define FSD_FC_XFER 8'h03
`define FSD_FC_NOP_04 8'h04
`define FSD_FC_APM_ON 8'h05
`define FSD_FC_NOP_33 8'h33
`define FSD_FC_NOP_54 8'h54
`define FSD_FC_RC_OFF 8'h55
`define FSD_FC_KEEP 8'h66
`define FSD_FC_NOP_77 8'h77
`define FSD_FC_NOP_81 8'h81
`define FSD_FC_WC_OFF 8'h82
`define FSD_FC_NOP_84 8'h84
`define FSD_FC_APM_OFF 8'h85
`define FSD_FC_NOP_88 8'h88
`define FSD_FC_NOP_89 8'h89
`define FSD_FC_RC_ON 8'haa
`define FSD_FC_NOP_AB 8'hab
`define FSD_FC_ECC4 8'hbb
`define FSD_FC_REVERT 8'hcc

// =====================================================================
// Transfer-mode argument types and highest mode numbers.
`define FSD_XT_PIO_DEF 5'h00
`define FSD_XT_PIO_FC 5'h01
`define FSD_XT_MWDMA 5'h04
`define FSD_XT_UDMA 5'h08
`define FSD_XM_PIO_MAX 3'h4
`define FSD_XM_MWDMA_MAX 3'h2
`define FSD_XM_UDMA_MAX 3'h4

// =====================================================================
// Status, error and unit-select bit positions.
`define FSD_ST_BUSY 7
`define FSD_ST_READY 6
`define FSD_ST_SEEKDONE 4
`define FSD_ST_ERR 0
`define FSD_ER_ABORT 2
`define FSD_UNIT_BIT 4

// =====================================================================
// Power-on defaults.
`define FSD_DEF_WCACHE 1'b1
`define FSD_DEF_RCACHE 1'b1
`define FSD_DEF_APM 1'b1
`define FSD_DEF_KEEP 1'b0
`define FSD_DEF_ECC4 1'b1
`define FSD_DEF_XFER 8'h00

`endif

// file: include/fsd_pkg.sv
// Types shared by the feature-set command decoder.
package fsd_pkg;

  // Sequencer states of one command.
  typedef enum logic [1:0] {
    FSD_IDLE,
    FSD_EXEC,
    FSD_DONE
  } fsd_state_e;

  // Drive settings that the feature command steers.
  typedef struct packed {
    logic write_cache;
    logic read_cache;
    logic apm;
    logic keep_soft;
    logic ecc4;
    logic [7:0] xfer_mode;
  } fsd_settings_s;

endpackage : fsd_pkg

// file: rtl/fsd_feature_apply.sv
// Computes the settings that a feature code produces, or an abort.
`timescale 1ns/1ns
`include "fsd_consts.svh"
module fsd_feature_apply (
  input wire logic [7:0] i_code,
  input wire logic [7:0] i_arg,
  input wire logic i_arg_ok,
  input wire fsd_pkg::fsd_settings_s i_cur,
  output fsd_pkg::fsd_settings_s o_nxt,
  output logic o_abort
);

  // Each code touches only its own field; unknown codes change nothing.
  always_comb begin
    o_nxt = i_cur;
    o_abort = 1'b0;
    case (i_code)
      `FSD_FC_WC_ON: o_nxt.write_cache = 1'b1;
      `FSD_FC_WC_OFF: o_nxt.write_cache = 1'b0;
      `FSD_FC_RC_ON: o_nxt.read_cache = 1'b1;
      `FSD_FC_RC_OFF: o_nxt.read_cache = 1'b0;
      `FSD_FC_APM_ON: o_nxt.apm = 1'b1;
      `FSD_FC_APM_OFF: o_nxt.apm = 1'b0;
      `FSD_FC_KEEP: o_nxt.keep_soft = 1'b1;
      `FSD_FC_REVERT: o_nxt.keep_soft = 1'b0;
      `FSD_FC_ECC4: o_nxt.ecc4 = 1'b1;
      `FSD_FC_XFER: begin
        // The recorded mode is advisory; the baseline modes are never withdrawn.
        if (i_arg_ok) begin
          o_nxt.xfer_mode = i_arg;
        end else begin
          o_abort = 1'b1;
        end
      end
      `FSD_FC_NOP_04, `FSD_FC_NOP_33, `FSD_FC_NOP_54, `FSD_FC_NOP_77,
      `FSD_FC_NOP_81, `FSD_FC_NOP_84, `FSD_FC_NOP_88, `FSD_FC_NOP_89,
      `FSD_FC_NOP_AB: o_nxt = i_cur;
      default: o_abort = 1'b1;
    endcase
  end

endmodule : fsd_feature_apply

// file: rtl/fsd_top.sv
// Task-file front end and command sequencer of the feature-set decoder.
`timescale 1ns/1ns
`include "fsd_consts.svh"
module fsd_top #(
  parameter logic UNIT_ID = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_soft_rst,
  input wire logic [9:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_busy,
  output logic o_identify_req,
  output fsd_pkg::fsd_settings_s o_settings
);

  // ===================================================================
  // Power-on settings.

  localparam fsd_pkg::fsd_settings_s DEF_SETTINGS = '{
    write_cache: `FSD_DEF_WCACHE,
    read_cache: `FSD_DEF_RCACHE,
    apm: `FSD_DEF_APM,
    keep_soft: `FSD_DEF_KEEP,
    ecc4: `FSD_DEF_ECC4,
    xfer_mode: `FSD_DEF_XFER
  };

  // ===================================================================
  // Declarations.

  logic [7:0] feature_ff;
  logic [7:0] nxt_feature;
  logic [7:0] scount_ff;
  logic [7:0] nxt_scount;
  logic [7:0] snumber_ff;
  logic [7:0] nxt_snumber;
  logic [7:0] cyl_lo_ff;
  logic [7:0] nxt_cyl_lo;
  logic [7:0] cyl_hi_ff;
  logic [7:0] nxt_cyl_hi;
  logic [7:0] drvhead_ff;
  logic [7:0] nxt_drvhead;

  fsd_pkg::fsd_state_e state_ff;
  fsd_pkg::fsd_state_e nxt_state;
  logic busy_ff;
  logic nxt_busy;
  logic err_ff;
  logic nxt_err;
  logic [7:0] fault_ff;
  logic [7:0] nxt_fault;
  logic irq_ff;
  logic nxt_irq;
  logic [7:0] opcode_ff;
  logic [7:0] nxt_opcode;
  logic [7:0] code_ff;
  logic [7:0] nxt_code;
  logic ident_ff;
  logic nxt_ident;

  fsd_pkg::fsd_settings_s settings_ff;
  fsd_pkg::fsd_settings_s nxt_settings;
  fsd_pkg::fsd_settings_s applied;

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic arg_ok;
  logic feat_abort;
  logic cmd_write;
  logic unit_match;
  logic status_read;
  logic [7:0] status_byte;

  // ===================================================================
  // Helpers.

  // Shadow registers may only be written while the drive is idle.
  assign unit_match = (drvhead_ff[`FSD_UNIT_BIT] == UNIT_ID);
  assign cmd_write = i_wr && (i_addr == `FSD_ADDR_COMMAND) && !busy_ff && unit_match;
  assign status_read = i_rd && (i_addr == `FSD_ADDR_COMMAND);

  // Ready and seek-complete are held high; the block has no media state.
  always_comb begin
    status_byte = 8'h00;
    status_byte[`FSD_ST_BUSY] = busy_ff;
    status_byte[`FSD_ST_READY] = 1'b1;
    status_byte[`FSD_ST_SEEKDONE] = 1'b1;
    status_byte[`FSD_ST_ERR] = err_ff;
  end

  // ===================================================================
  // Feature decoding.

  // Argument check and the settings that the captured code would yield.
  fsd_xfer_check u_xfer_check (
    .i_arg(scount_ff),
    .o_ok(arg_ok)
  );

  fsd_feature_apply u_feature_apply (
    .i_code(code_ff),
    .i_arg(scount_ff),
    .i_arg_ok(arg_ok),
    .i_cur(settings_ff),
    .o_nxt(applied),
    .o_abort(feat_abort)
  );

  // ===================================================================
  // Task-file shadow registers.

  // Host writes are dropped while busy, so the sequencer sees stable arguments.
  always_comb begin
    nxt_feature = feature_ff;
    nxt_scount = scount_ff;
    nxt_snumber = snumber_ff;
    nxt_cyl_lo = cyl_lo_ff;
    nxt_cyl_hi = cyl_hi_ff;
    nxt_drvhead = drvhead_ff;
    if (i_wr && !busy_ff) begin
      case (i_addr)
        `FSD_ADDR_FEATURE: nxt_feature = i_wdata;
        `FSD_ADDR_SCOUNT: nxt_scount = i_wdata;
        `FSD_ADDR_SNUMBER: nxt_snumber = i_wdata;
        `FSD_ADDR_CYL_LO: nxt_cyl_lo = i_wdata;
        `FSD_ADDR_CYL_HI: nxt_cyl_hi = i_wdata;
        `FSD_ADDR_DRVHEAD: nxt_drvhead = i_wdata;
        default: nxt_feature = feature_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      feature_ff <= 8'h00;
      scount_ff <= 8'h00;
      snumber_ff <= 8'h00;
      cyl_lo_ff <= 8'h00;
      cyl_hi_ff <= 8'h00;
      drvhead_ff <= 8'h00;
    end else if (i_ce) begin
      feature_ff <= nxt_feature;
      scount_ff <= nxt_scount;
      snumber_ff <= nxt_snumber;
      cyl_lo_ff <= nxt_cyl_lo;
      cyl_hi_ff <= nxt_cyl_hi;
      drvhead_ff <= nxt_drvhead;
    end
  end

  // ===================================================================
  // Command sequencer.

  // Busy drops one cycle before the interrupt rises, so a host that sees
  // the interrupt never reads a stale busy flag.
  always_comb begin
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_err = err_ff;
    nxt_fault = fault_ff;
    nxt_irq = irq_ff;
    nxt_opcode = opcode_ff;
    nxt_code = code_ff;
    nxt_ident = 1'b0;
    // Reading status acknowledges the interrupt.
    if (status_read) begin
      nxt_irq = 1'b0;
    end
    case (state_ff)
      fsd_pkg::FSD_IDLE: begin
        if (cmd_write) begin
          nxt_irq = 1'b0;
          nxt_err = 1'b0;
          nxt_fault = 8'h00;
          nxt_opcode = i_wdata;
          nxt_busy = 1'b1;
          nxt_code = feature_ff;
          nxt_state = fsd_pkg::FSD_EXEC;
        end
      end
      fsd_pkg::FSD_EXEC: begin
        nxt_busy = 1'b0;
        nxt_state = fsd_pkg::FSD_DONE;
        case (opcode_ff)
          `FSD_OP_SET_FEAT: begin
            if (feat_abort) begin
              nxt_err = 1'b1;
              nxt_fault[`FSD_ER_ABORT] = 1'b1;
            end
          end
          `FSD_OP_IDENT_DMA: nxt_ident = 1'b1;
          default: begin
            nxt_err = 1'b1;
            nxt_fault[`FSD_ER_ABORT] = 1'b1;
          end
        endcase
      end
      fsd_pkg::FSD_DONE: begin
        nxt_irq = 1'b1;
        nxt_state = fsd_pkg::FSD_IDLE;
      end
      default: nxt_state = fsd_pkg::FSD_IDLE;
    endcase
    // Software reset abandons a command in flight.
    if (i_soft_rst) begin
      nxt_state = fsd_pkg::FSD_IDLE;
      nxt_busy = 1'b0;
      nxt_err = 1'b0;
      nxt_fault = 8'h00;
      nxt_irq = 1'b0;
      nxt_ident = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= fsd_pkg::FSD_IDLE;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      fault_ff <= 8'h00;
      irq_ff <= 1'b0;
      opcode_ff <= 8'h00;
      code_ff <= 8'h00;
      ident_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      err_ff <= nxt_err;
      fault_ff <= nxt_fault;
      irq_ff <= nxt_irq;
      opcode_ff <= nxt_opcode;
      code_ff <= nxt_code;
      ident_ff <= nxt_ident;
    end
  end

  // ===================================================================
  // Drive settings.

  // Settings change only on a feature command that was not refused, or on soft reset.
  always_comb begin
    nxt_settings = settings_ff;
    if ((state_ff == fsd_pkg::FSD_EXEC) && (opcode_ff == `FSD_OP_SET_FEAT) && !feat_abort) begin
      nxt_settings = applied;
    end
    // Unless retention was asked for, soft reset restores the above-AA group.
    if (i_soft_rst && !settings_ff.keep_soft) begin
      nxt_settings.ecc4 = DEF_SETTINGS.ecc4;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      settings_ff <= DEF_SETTINGS;
    end else if (i_ce) begin
      settings_ff <= nxt_settings;
    end
  end

  // ===================================================================
  // Read path.

  // Read data is registered; it appears the cycle after the strobe.
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `FSD_ADDR_FEATURE: nxt_rdata = fault_ff;
        `FSD_ADDR_SCOUNT: nxt_rdata = scount_ff;
        `FSD_ADDR_SNUMBER: nxt_rdata = snumber_ff;
        `FSD_ADDR_CYL_LO: nxt_rdata = cyl_lo_ff;
        `FSD_ADDR_CYL_HI: nxt_rdata = cyl_hi_ff;
        `FSD_ADDR_DRVHEAD: nxt_rdata = drvhead_ff;
        `FSD_ADDR_COMMAND: nxt_rdata = status_byte;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= 8'h00;
    end else if (i_ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ===================================================================
  // Outputs.

  assign o_rdata = rdata_ff;
  assign o_irq = irq_ff;
  assign o_busy = busy_ff;
  assign o_identify_req = ident_ff;
  assign o_settings = settings_ff;

endmodule : fsd_top

// file: rtl/fsd_xfer_check.sv
// Checks a transfer-mode argument against the supported encodings.
`timescale 1ns/1ns
`include "fsd_consts.svh"
module fsd_xfer_check (
  input wire logic [7:0] i_arg,
  output logic o_ok
);

  logic [4:0] xfer_type;
  logic [2:0] xfer_num;

  // Split the argument into type and mode number.
  assign xfer_type = i_arg[7:3];
  assign xfer_num = i_arg[2:0];

  // Any type or mode number outside the table is refused.
  always_comb begin
    case (xfer_type)
      `FSD_XT_PIO_DEF: o_ok = (xfer_num == 3'h0);
      `FSD_XT_PIO_FC: o_ok = (xfer_num <= `FSD_XM_PIO_MAX);
      `FSD_XT_MWDMA: o_ok = (xfer_num <= `FSD_XM_MWDMA_MAX);
      `FSD_XT_UDMA: o_ok = (xfer_num <= `FSD_XM_UDMA_MAX);
      default: o_ok = 1'b0;
    endcase
  end

endmodule : fsd_xfer_check

// file: test/feature_set_command_decoder_bench.sv
// Self-checking bench of the feature-set command decoder.
`timescale 1ns/1ns
module feature_set_command_decoder_bench;
  // ====
  // Wiring, table rows and counters.
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] arg;
    logic err;
    logic [12:0] sets;
  } fsd_row_s;
  logic clk, rst, ce, soft_rst, wr, rd, irq, busy, ident;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, stat, fault;
  fsd_pkg::fsd_settings_s sets;
  bit irq_seen, id_seen;
  int fail_count = 0;
  int compares = 0;
  fsd_row_s rows [0:28] = '{
    '{8'h82, 8'h00, 1'b0, 13'h0d00}, '{8'h04, 8'h00, 1'b0, 13'h0d00},
    '{8'h33, 8'h00, 1'b0, 13'h0d00}, '{8'h54, 8'h00, 1'b0, 13'h0d00},
    '{8'h77, 8'h00, 1'b0, 13'h0d00}, '{8'h81, 8'h00, 1'b0, 13'h0d00},
    '{8'h84, 8'h00, 1'b0, 13'h0d00}, '{8'h88, 8'h00, 1'b0, 13'h0d00},
    '{8'h89, 8'h00, 1'b0, 13'h0d00}, '{8'hab, 8'h00, 1'b0, 13'h0d00},
    '{8'h02, 8'h00, 1'b0, 13'h1d00}, '{8'h55, 8'h00, 1'b0, 13'h1500},
    '{8'haa, 8'h00, 1'b0, 13'h1d00}, '{8'h85, 8'h00, 1'b0, 13'h1900},
    '{8'h05, 8'h00, 1'b0, 13'h1d00}, '{8'h66, 8'h00, 1'b0, 13'h1f00},
    '{8'hcc, 8'h00, 1'b0, 13'h1d00}, '{8'hbb, 8'h00, 1'b0, 13'h1d00},
    '{8'h03, 8'h0c, 1'b0, 13'h1d0c}, '{8'h03, 8'h22, 1'b0, 13'h1d22},
    '{8'h03, 8'h44, 1'b0, 13'h1d44}, '{8'h03, 8'h00, 1'b0, 13'h1d00},
    '{8'h03, 8'h0d, 1'b1, 13'h1d00}, '{8'h03, 8'h23, 1'b1, 13'h1d00},
    '{8'h03, 8'h45, 1'b1, 13'h1d00}, '{8'h03, 8'h10, 1'b1, 13'h1d00},
    '{8'h00, 8'h00, 1'b1, 13'h1d00}, '{8'h01, 8'h00, 1'b1, 13'h1d00},
    '{8'hff, 8'h00, 1'b1, 13'h1d00}};

  fsd_top dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_soft_rst(soft_rst), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_irq(irq), .o_busy(busy),
    .o_identify_req(ident), .o_settings(sets));
  fsd_host host_u (.i_clk(clk), .i_rdata(rdata), .i_irq(irq), .i_identify_req(ident),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  // Compare, count and report a mismatch at once.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Verdict and end of run.
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang is cut well beyond the roughly five hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // ====
  // Reset, table loop, then the awkward cases.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    soft_rst = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("reset_settings", 16'h1d00, 16'(sets));
    foreach (rows[i]) begin
      host_u.cmd(1'b0, 8'hef, rows[i].code, rows[i].arg, stat, fault, irq_seen, id_seen);
      chk("irq_seen", 16'h0001, 16'(irq_seen));
      chk("status", 16'({7'h28, rows[i].err}), 16'(stat));
      chk("fault", rows[i].err ? 16'h0004 : 16'h0000, 16'(fault));
      chk("settings", 16'(rows[i].sets), 16'(sets));
      chk("irq_cleared", 16'h0000, 16'(irq));
      chk("no_identify", 16'h0000, 16'(id_seen));
    end
    // Identify through the DMA opcode completes like plain identify.
    host_u.cmd(1'b0, 8'hee, 8'h00, 8'h00, stat, fault, irq_seen, id_seen);
    chk("identify", 16'h0001, 16'(id_seen));
    chk("identify_status", 16'h0050, 16'(stat));
    // An opcode outside the two decoded ones is aborted and leaves the settings alone.
    host_u.cmd(1'b0, 8'h00, 8'h82, 8'h00, stat, fault, irq_seen, id_seen);
    chk("bad_opcode_status", 16'h0051, 16'(stat));
    chk("bad_opcode_fault", 16'h0004, 16'(fault));
    chk("bad_opcode_settings", 16'h1d00, 16'(sets));
    // A command written while the clock enable is low is lost; busy would show at once.
    ce = 1'b0;
    host_u.wr(10'h1f7, 8'hef);
    chk("frozen_busy", 16'h0000, 16'(busy));
    ce = 1'b1;
    @(negedge clk);
    chk("frozen_irq", 16'h0000, 16'(irq));
    // The other unit is addressed, so the command is refused.
    host_u.cmd(1'b1, 8'hef, 8'h82, 8'h00, stat, fault, irq_seen, id_seen);
    chk("other_unit_irq", 16'h0000, 16'(irq_seen));
    chk("other_unit_settings", 16'h1d00, 16'(sets));
    // Soft reset with an interrupt pending keeps the cache setting.
    host_u.cmd(1'b0, 8'hef, 8'h82, 8'h00, stat, fault, irq_seen, id_seen);
    host_u.wr(10'h1f7, 8'hef);
    repeat (2) @(negedge clk);
    chk("irq_before_soft", 16'h0001, 16'(irq));
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    chk("irq_after_soft", 16'h0000, 16'(irq));
    chk("soft_settings", 16'h0d00, 16'(sets));
    host_u.rd(10'h1f0, stat);
    chk("unmapped_read", 16'h0000, 16'(stat));
    complete_run();
  end
endmodule : feature_set_command_decoder_bench

// file: test/fsd_chk.sv
// Checker of the command sequence and settings of the feature decoder.
`timescale 1ns/1ns
module fsd_chk #(
  parameter logic UNIT_ID = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_soft_rst,
  input wire logic [9:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_busy,
  input wire logic o_identify_req,
  input wire fsd_pkg::fsd_settings_s o_settings
);
  // ====
  // Shadows of host writes; writes during busy are dropped, as in the device.
  logic [7:0] code_ff, nxt_code, arg_ff, nxt_arg;
  logic sel_ff, nxt_sel, wr_ok, cmd_go, ef_go;
  always_comb begin
    wr_ok = i_ce && i_wr && !o_busy;
    nxt_code = (wr_ok && i_addr == 10'h1f1) ? i_wdata : code_ff;
    nxt_arg = (wr_ok && i_addr == 10'h1f2) ? i_wdata : arg_ff;
    nxt_sel = (wr_ok && i_addr == 10'h1f6) ? i_wdata[4] : sel_ff;
    cmd_go = wr_ok && i_addr == 10'h1f7 && sel_ff == UNIT_ID;
    ef_go = cmd_go && i_wdata == 8'hef;
  end
  // Shadow registers.
  always_ff @(posedge i_clk) begin
    code_ff <= nxt_code;
    arg_ff <= nxt_arg;
    sel_ff <= nxt_sel;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ====
  // Protocol and settings relations.
  AST_CMD_BUSY: assert property (cmd_go |=> o_busy)
    else $error("busy not raised by command");
  AST_BUSY_PULSE: assert property (o_busy |=> !o_busy)
    else $error("busy longer than one cycle");
  AST_IRQ_AFTER: assert property ($fell(o_busy) && !$past(i_soft_rst) && !i_soft_rst
    |-> !o_irq ##1 o_irq)
    else $error("interrupt not one cycle after busy clear");
  AST_IDENT: assert property (o_identify_req |-> $past(o_busy) && !o_busy)
    else $error("identify pulse outside completion");
  AST_QUIET: assert property (!$stable(o_settings) |-> $past(o_busy) || $past(i_soft_rst))
    else $error("settings changed outside a command");
  AST_WCACHE: assert property (ef_go && code_ff == 8'h02 |-> ##2 o_settings.write_cache)
    else $error("write cache not enabled");
  AST_RCACHE: assert property (ef_go && code_ff == 8'h55 |-> ##2 !o_settings.read_cache)
    else $error("read cache not disabled");
  AST_XFER: assert property (ef_go && code_ff == 8'h03
    && arg_ff inside {8'h00, [8'h08:8'h0c], [8'h20:8'h22], [8'h40:8'h44]}
    |-> ##2 o_settings.xfer_mode == $past(arg_ff, 2))
    else $error("transfer mode not stored");
  AST_SOFT_ECC: assert property (i_ce && i_soft_rst && !o_settings.keep_soft
    |=> o_settings.ecc4)
    else $error("soft reset did not restore ecc");
  AST_RESET: assert property (disable iff (1'b0) i_ce && i_rst
    |=> o_settings == 13'h1d00 && !o_busy && !o_irq)
    else $error("reset defaults wrong");
  AST_SOFT_CLR: assert property (i_ce && i_soft_rst |=> !o_busy && !o_irq)
    else $error("soft reset left busy or interrupt");
  AST_SOFT_KEEP: assert property (i_ce && i_soft_rst && !o_busy |=>
    o_settings[12:9] == $past(o_settings[12:9])
    && o_settings.xfer_mode == $past(o_settings.xfer_mode))
    else $error("soft reset changed a retained setting");

  // Main scenarios reached.
  cover property (ef_go);
  cover property ($fell(o_busy) ##1 o_irq);
  cover property (o_identify_req);
endmodule : fsd_chk

bind fsd_top fsd_chk #(.UNIT_ID(UNIT_ID)) chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_soft_rst(i_soft_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_busy(o_busy), .o_identify_req(o_identify_req),
  .o_settings(o_settings));

// file: test/fsd_host.sv
// Host controller model that drives the task-file registers.
`timescale 1ns/1ns
module fsd_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_irq,
  input wire logic i_identify_req,
  output logic [9:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // ====
  // Idle bus at time zero.
  initial begin
    o_addr = 10'h000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // One write; released lines are inverted so stale values never look valid.
  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    o_addr = addr;
    o_wdata = data;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~addr;
    o_wdata = ~data;
  endtask : wr

  // One read; data is taken a cycle after the strobe edge.
  task automatic rd(input logic [9:0] addr, output logic [7:0] data);
    @(negedge i_clk);
    o_addr = addr;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~addr;
    data = i_rdata;
  endtask : rd

  // Full command: unit, argument, code, opcode, bounded wait, then status and fault.
  task automatic cmd(input logic unit, input logic [7:0] op, input logic [7:0] code,
    input logic [7:0] arg, output logic [7:0] stat, output logic [7:0] fault,
    output bit irq_seen, output bit id_seen);
    wr(10'h1f6, {3'h0, unit, 4'h0});
    wr(10'h1f2, arg);
    wr(10'h1f1, code);
    wr(10'h1f7, op);
    irq_seen = 1'b0;
    id_seen = 1'b0;
    for (int n = 0; n < 8 && !irq_seen; n++) begin
      @(negedge i_clk);
      id_seen = id_seen | i_identify_req;
      irq_seen = i_irq;
    end
    rd(10'h1f7, stat);
    rd(10'h1f1, fault);
  endtask : cmd
endmodule : fsd_host
